// [design/pulse_stretcher.sv]
// holds its output high while the trigger is high and for a minimum time after
// assumes trigger is synchronous to clk_i
`timescale 1ns/10ps
`default_nettype none

module pulse_stretcher #(
  parameter int unsigned CW = 8,
  parameter logic [CW-1:0] MIN_CYC = 8'h14
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // request and stretched level
  input wire logic trig_i,
  output logic active_o
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // reload on trigger, otherwise run down to zero
  assign cnt_d = trig_i ? (MIN_CYC - 1'b1) : ((cnt_q != '0) ? (cnt_q - 1'b1) : cnt_q);
  assign active_o = trig_i | (cnt_q != '0);

  // ==========================================================
  // counter
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

// [design/reset_seq_pkg.sv]
// constants, modes and carrier types of the reset sequencer and supply monitor
// assumes a single 20 MHz cpu clock; analog comparators live outside this logic
package reset_seq_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  // minimum width of a reset pulse that the device drives out, in ns
  localparam int unsigned RST_OUT_MIN_NS = 1000;
  // least time, so round up to whole cycles
  localparam int unsigned RST_OUT_MIN_CYC = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_SHORT_CYC = 256;
  localparam int unsigned DELAY_LONG_CYC = 4096;
  localparam int unsigned FETCH_CYC = 2;
  localparam int unsigned DELAY_CNT_W = 13;
  localparam int unsigned STRETCH_CNT_W = 8;

  // ==========================================================
  // reset vector location
  localparam logic [15:0] VEC_ADDR_LO = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_HI = 16'hFFFF;

  // ==========================================================
  // reset values
  localparam logic FLAG_RST = 1'b0;

  // ==========================================================
  // sequence phases
  typedef enum logic [1:0] {
    SEQ_ACTIVE,
    SEQ_DELAY,
    SEQ_FETCH,
    SEQ_RUN
  } seq_state_e;

  // non-volatile option settings
  typedef struct packed {
    logic long_delay;
    logic undervoltage_detector_en;
    logic osc_is_resonator;
  } option_s;

  // software side of the integrity control/status bits
  typedef struct packed {
    logic supply_warning_irq_en;
    logic clr_watchdog_flag;
    logic clr_undervoltage_flag;
    logic isr_enter;
  } sw_ctrl_s;

  // integrity_ctrl_status read-back
  typedef struct packed {
    logic supply_warning_irq_en;
    logic supply_warning_flag;
    logic undervoltage_reset_flag;
    logic watchdog_reset_flag;
  } status_s;

endpackage

// [design/reset_sequence_and_supply_monitor.sv]
// reset sequencer and supply integrity logic of an 8-bit microcontroller
// assumes comparator outputs and the watchdog pulse are synchronous to clk_i;
// the reset pin is an open-drain wire resolved by the surroundings
`timescale 1ns/10ps
`default_nettype none

module reset_sequence_and_supply_monitor
  import reset_seq_pkg::*;
#(
  parameter int unsigned DELAY_SHORT = DELAY_SHORT_CYC,
  parameter int unsigned DELAY_LONG = DELAY_LONG_CYC,
  parameter int unsigned RST_OUT_MIN = RST_OUT_MIN_CYC
) (
  // clock and power-on reset of this logic
  input wire logic clk_i,
  input wire logic reset_n_i,
  // open-drain reset pin
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  // option settings
  input wire option_s opt_i,
  // analog comparators and watchdog
  input wire logic undervoltage_low_i,
  input wire logic supply_warning_cmp_i,
  input wire logic watchdog_underflow_i,
  output logic undervoltage_thr_upper_o,
  output logic supply_warning_thr_upper_o,
  // software control bits
  input wire sw_ctrl_s sw_i,
  // core side
  output logic cpu_reset_o,
  output logic vector_fetch_o,
  output logic [15:0] vector_addr_o,
  output logic osc_keep_running_o,
  // status and interrupt
  output status_s status_o,
  output logic supply_warning_irq_o
);

  // ==========================================================
  // declarations
  seq_state_e state_q;
  seq_state_e state_d;
  logic [DELAY_CNT_W-1:0] delay_cnt_q;
  logic [DELAY_CNT_W-1:0] delay_cnt_d;
  logic [DELAY_CNT_W-1:0] delay_last;
  logic fetch_cnt_q;
  logic ext_seen_q;
  logic pin_oe_q;
  logic ext_trig;
  logic own_pull;
  logic [DELAY_CNT_W-1:0] chk_dly_q;
  logic ext_active;
  logic wdg_active;
  logic uv_active;
  logic src_any;
  logic delay_done;
  logic fetch_done;
  logic vec_fetch_q;
  logic [15:0] vec_addr_q;
  logic wdg_flag_q;
  logic uv_flag_q;
  logic warn_flag_q;
  logic warn_prev_q;
  logic irq_en_prev_q;
  logic warn_toggle;
  logic irq_en_rise;
  logic pend_set;
  logic pend_q;

  // ==========================================================
  // reset sources
  // pin low seen with no clock edge: async set with a constant only
  always_ff @(posedge clk_i or negedge rst_pin_i) begin
    if (!rst_pin_i) begin
      ext_seen_q <= 1'b1;
    end else begin
      ext_seen_q <= 1'b0;
    end
  end

  // registered drive, so our own pull-down is never mistaken for an external one
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_oe_q <= 1'b1;
    end else begin
      pin_oe_q <= rst_pin_oe_o;
    end
  end

  // our own pull, known before the registered copy catches up a cycle later
  assign own_pull = wdg_active | uv_active | (state_q == SEQ_ACTIVE) | (state_q == SEQ_DELAY);
  // limitation: while the device itself drives the pin an external pulse is hidden
  assign ext_trig = ext_seen_q & ~pin_oe_q & ~own_pull;

  // stretch external pulses to the minimum output width
  pulse_stretcher #(
    .CW(STRETCH_CNT_W),
    .MIN_CYC(STRETCH_CNT_W'(RST_OUT_MIN))
  ) u_ext_stretch (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .trig_i(ext_trig),
    .active_o(ext_active)
  );

  // watchdog underflow pulse held out for the minimum width
  pulse_stretcher #(
    .CW(STRETCH_CNT_W),
    .MIN_CYC(STRETCH_CNT_W'(RST_OUT_MIN))
  ) u_wdg_stretch (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .trig_i(watchdog_underflow_i),
    .active_o(wdg_active)
  );

  // static undervoltage reset, gated by its option
  assign uv_active = opt_i.undervoltage_detector_en & undervoltage_low_i;
  // upper threshold watched while undervoltage holds reset (rising), lower otherwise
  assign undervoltage_thr_upper_o = uv_active;
  assign src_any = ext_active | wdg_active | uv_active;

  // ==========================================================
  // sequence decode
  assign delay_last = opt_i.long_delay ? DELAY_CNT_W'(DELAY_LONG - 1) :
                      DELAY_CNT_W'(DELAY_SHORT - 1);
  assign delay_done = (delay_cnt_q == delay_last);
  assign fetch_done = (fetch_cnt_q == 1'(FETCH_CYC - 1));

  // phases in order, any reassert falls back to the active phase
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_ACTIVE: begin
        if (!src_any) begin
          state_d = SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        if (src_any) begin
          state_d = SEQ_ACTIVE;
        end else if (delay_done) begin
          state_d = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        if (src_any) begin
          state_d = SEQ_ACTIVE;
        end else if (fetch_done) begin
          state_d = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (src_any) begin
          state_d = SEQ_ACTIVE;
        end
      end
      default: begin
        state_d = SEQ_ACTIVE;
      end
    endcase
  end

  // delay counter runs only inside the delay phase
  assign delay_cnt_d = (state_q == SEQ_DELAY && !src_any) ? (delay_cnt_q + 1'b1) : '0;

  // ==========================================================
  // sequence registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= SEQ_ACTIVE;
      delay_cnt_q <= '0;
      fetch_cnt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      delay_cnt_q <= delay_cnt_d;
      fetch_cnt_q <= (state_q == SEQ_FETCH) ? ~fetch_cnt_q : 1'b0;
    end
  end

  // vector fetch strobe and address, low byte first
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      vec_fetch_q <= 1'b0;
      vec_addr_q <= VEC_ADDR_LO;
    end else begin
      vec_fetch_q <= (state_d == SEQ_FETCH);
      vec_addr_q <= (state_d == SEQ_FETCH && state_q == SEQ_FETCH) ? VEC_ADDR_HI : VEC_ADDR_LO;
    end
  end

  // ==========================================================
  // pin and core outputs
  // open drain: the data level is always low, only the enable moves
  assign rst_pin_o = 1'b0;
  // no release between active and delay phase, so the wire never glitches high
  assign rst_pin_oe_o = ext_active | own_pull;
  assign cpu_reset_o = (state_q != SEQ_RUN);
  assign vector_fetch_o = vec_fetch_q;
  assign vector_addr_o = vec_addr_q;
  // resonators never stop, so no start-up time is lost in reset
  assign osc_keep_running_o = opt_i.osc_is_resonator | (state_q == SEQ_RUN);

  // ==========================================================
  // reset cause flags
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wdg_flag_q <= FLAG_RST;
      uv_flag_q <= FLAG_RST;
    end else begin
      if (watchdog_underflow_i) begin
        wdg_flag_q <= 1'b1;
      end else if (sw_i.clr_watchdog_flag || uv_active) begin
        wdg_flag_q <= 1'b0;
      end
      if (uv_active) begin
        uv_flag_q <= 1'b1;
      end else if (sw_i.clr_undervoltage_flag) begin
        uv_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // supply warning detector
  // real-time copy of the comparator, dead without the undervoltage option
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      warn_flag_q <= FLAG_RST;
      warn_prev_q <= FLAG_RST;
      irq_en_prev_q <= 1'b0;
    end else begin
      warn_flag_q <= opt_i.undervoltage_detector_en & supply_warning_cmp_i;
      warn_prev_q <= warn_flag_q;
      irq_en_prev_q <= sw_i.supply_warning_irq_en;
    end
  end

  assign supply_warning_thr_upper_o = warn_flag_q;
  // crossings while the sequencer still holds reset are swallowed
  assign warn_toggle = (warn_flag_q != warn_prev_q) && (state_q == SEQ_RUN);
  assign irq_en_rise = sw_i.supply_warning_irq_en & ~irq_en_prev_q;
  // enabling while under threshold raises one at once
  assign pend_set = warn_toggle | (irq_en_rise & warn_flag_q & (state_q == SEQ_RUN));

  // pending kept while disabled so a late enable still sees one
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pend_q <= 1'b0;
    end else if (pend_set) begin
      pend_q <= 1'b1;
    end else if (sw_i.isr_enter) begin
      pend_q <= 1'b0;
    end
  end

  assign supply_warning_irq_o = pend_q & sw_i.supply_warning_irq_en;

  assign status_o.supply_warning_irq_en = sw_i.supply_warning_irq_en;
  assign status_o.supply_warning_flag = warn_flag_q;
  assign status_o.undervoltage_reset_flag = uv_flag_q;
  assign status_o.watchdog_reset_flag = wdg_flag_q;

  // ==========================================================
  // checks
  sequence s_fetch_two;
    vector_fetch_o && vector_addr_o == VEC_ADDR_LO ##1 vector_fetch_o && vector_addr_o == VEC_ADDR_HI;
  endsequence

  sequence s_fetch_end;
    !vector_fetch_o;
  endsequence

  chk_vector_fetch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(vector_fetch_o) && state_q == SEQ_FETCH && !src_any |-> s_fetch_two)
    else $error("vector fetch address order wrong");

  chk_fetch_length: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == SEQ_FETCH && fetch_cnt_q && !src_any |=> state_q == SEQ_RUN ##1 s_fetch_end)
    else $error("vector fetch not two cycles");

  chk_pin_in_delay: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == SEQ_DELAY |-> rst_pin_oe_o && !rst_pin_o && cpu_reset_o)
    else $error("reset pin released during delay");

  chk_uv_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    uv_active |=> rst_pin_oe_o && state_q == SEQ_ACTIVE && undervoltage_thr_upper_o == uv_active)
    else $error("undervoltage did not hold reset");

  // cycles spent in the delay phase, counted apart from the sequencer's own counter
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      chk_dly_q <= '0;
    end else begin
      chk_dly_q <= (state_q == SEQ_DELAY) ? (chk_dly_q + 1'b1) : '0;
    end
  end

  chk_short_delay: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == SEQ_DELAY && !opt_i.long_delay && !src_any && chk_dly_q == DELAY_CNT_W'(DELAY_SHORT - 1)
    |=> state_q == SEQ_FETCH)
    else $error("short delay count wrong");

  chk_delay_early: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == SEQ_DELAY && !src_any && chk_dly_q < (opt_i.long_delay ? DELAY_LONG : DELAY_SHORT) - 1
    |=> state_q == SEQ_DELAY)
    else $error("delay phase ended early");

  chk_wdg_stretch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    watchdog_underflow_i |=> (wdg_active && rst_pin_oe_o)[*8])
    else $error("watchdog pulse too short");

  chk_delay_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q inside {SEQ_DELAY, SEQ_FETCH, SEQ_RUN} && src_any |=> state_q == SEQ_ACTIVE && delay_cnt_q == '0)
    else $error("delay did not restart");

  chk_wdg_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    watchdog_underflow_i |=> status_o.watchdog_reset_flag)
    else $error("watchdog flag not set");

  chk_uv_flag_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    status_o.undervoltage_reset_flag && !sw_i.clr_undervoltage_flag |=> status_o.undervoltage_reset_flag)
    else $error("undervoltage flag lost");

  chk_warn_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !opt_i.undervoltage_detector_en ##1 !opt_i.undervoltage_detector_en |-> !status_o.supply_warning_flag)
    else $error("warning flag live without option");

  chk_no_irq_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q != SEQ_RUN && !pend_q |=> !pend_q)
    else $error("warning interrupt raised in reset");

  chk_toggle_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == SEQ_RUN && $changed(warn_flag_q) && sw_i.supply_warning_irq_en ##1
    sw_i.supply_warning_irq_en |-> supply_warning_irq_o)
    else $error("toggle gave no interrupt");

  chk_isr_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sw_i.isr_enter && !pend_set |=> !supply_warning_irq_o)
    else $error("pending not cleared on service entry");

endmodule

`default_nettype wire

// [verification/reset_line_model.sv]
// external reset circuitry sharing the open-drain reset wire with the device
// assumes a weak pull-up: the wire is high unless some party pulls it low
`timescale 1ns/10ps
`default_nettype none

module reset_line_model (
  // pull request of the outside circuit
  input wire logic ext_pull_i,
  // device side of the pin
  input wire logic dev_o_i,
  input wire logic dev_oe_i,
  // resolved wire level
  output logic pin_o
);
  // =====================================
  // wired-and with pull-up
  // no keeper: a released wire goes straight back to the pull-up level
  assign pin_o = !(ext_pull_i || (dev_oe_i && !dev_o_i));
endmodule

`default_nettype wire

// [verification/reset_sequence_and_supply_monitor_test.sv]
// self-checking bench of the reset sequencer and supply monitor
// assumes shortened delays (8 and 16) and inputs driven at the falling edge
`timescale 1ns/10ps
`default_nettype none

module reset_sequence_and_supply_monitor_test;
  import reset_seq_pkg::*;
  localparam int DS = 8;
  localparam int DL = 16;
  localparam int RM = RST_OUT_MIN_CYC;
  // =====================================
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ext_pull = 1'b0;
  logic rst_pin_i;
  logic rst_pin_o;
  logic rst_pin_oe_o;
  option_s opt_i = '0;
  logic uv_low = 1'b0;
  logic cmp = 1'b0;
  logic wdg = 1'b0;
  sw_ctrl_s sw_i = '0;
  logic cpu_reset_o;
  logic vector_fetch_o;
  logic [15:0] vector_addr_o;
  logic osc_keep_running_o;
  status_s status_o;
  logic irq_o;
  logic uv_thr;
  logic warn_thr;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] seed = 8'h04;

  always #25 clk_i = ~clk_i;

  reset_line_model line (.ext_pull_i(ext_pull), .dev_o_i(rst_pin_o), .dev_oe_i(rst_pin_oe_o), .pin_o(rst_pin_i));

  reset_sequence_and_supply_monitor #(.DELAY_SHORT(DS), .DELAY_LONG(DL), .RST_OUT_MIN(RM)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_o(rst_pin_oe_o), .opt_i(opt_i), .undervoltage_low_i(uv_low),
    .supply_warning_cmp_i(cmp), .watchdog_underflow_i(wdg), .undervoltage_thr_upper_o(uv_thr),
    .supply_warning_thr_upper_o(warn_thr), .sw_i(sw_i), .cpu_reset_o(cpu_reset_o),
    .vector_fetch_o(vector_fetch_o), .vector_addr_o(vector_addr_o),
    .osc_keep_running_o(osc_keep_running_o), .status_o(status_o), .supply_warning_irq_o(irq_o));

  // =====================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // fetch then run; entered at the negedge where fetch first shows
  task automatic fetch_tail();
    check("fetch", vector_fetch_o, 1'b1);
    check("addr_lo", vector_addr_o, VEC_ADDR_LO);
    @(negedge clk_i);
    check("fetch2", vector_fetch_o, 1'b1);
    check("addr_hi", vector_addr_o, VEC_ADDR_HI);
    @(negedge clk_i);
    check("fetch_end", vector_fetch_o, 1'b0);
    check("core_run", cpu_reset_o, 1'b0);
    check("pin_free", rst_pin_oe_o, 1'b0);
  endtask

  // power-on reset, then an exact delay phase of n cycles
  task automatic por(input logic long_d, input logic uv_en);
    int n;
    n = long_d ? DL : DS;
    reset_n_i = 1'b0;
    seed = lfsr_next(seed);
    opt_i = '{long_delay: long_d, undervoltage_detector_en: uv_en, osc_is_resonator: seed[0]};
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      check("delay_pin", rst_pin_oe_o, 1'b1);
      check("delay_wire", rst_pin_i, 1'b0);
      check("delay_fetch", vector_fetch_o, 1'b0);
      check("delay_core", cpu_reset_o, 1'b1);
      check("osc_keep", osc_keep_running_o, opt_i.osc_is_resonator);
    end
    @(negedge clk_i);
    fetch_tail();
  endtask

  // a source was just applied: count cycles until fetch, pin low early on
  task automatic hold_check(input int min_cyc, input int oe_cyc);
    int cnt;
    cnt = 0;
    @(negedge clk_i);
    while (vector_fetch_o !== 1'b1 && cnt < 500) begin
      if (cnt < oe_cyc) begin
        check("src_pin", rst_pin_oe_o, 1'b1);
      end
      cnt++;
      @(negedge clk_i);
    end
    check("hold_len", cnt >= min_cyc, 1'b1);
    fetch_tail();
  endtask

  task automatic pulse_wdg();
    @(negedge clk_i);
    wdg = 1'b1;
    @(negedge clk_i);
    wdg = 1'b0;
  endtask

  task automatic sw_pulse(input sw_ctrl_s p);
    @(negedge clk_i);
    sw_i = p | sw_i;
    @(negedge clk_i);
    sw_i = '{supply_warning_irq_en: sw_i.supply_warning_irq_en, default: 1'b0};
  endtask

  task automatic set_cmp(input logic v);
    @(negedge clk_i);
    cmp = v;
    repeat (3) @(negedge clk_i);
  endtask

  // =====================================
  // main sequence
  initial begin
    int len;
    por(1'b1, 1'b0);
    por(1'b0, 1'b0);
    // detector disabled: low supply and warning have no effect
    @(negedge clk_i);
    uv_low = 1'b1;
    cmp = 1'b1;
    repeat (4) @(negedge clk_i);
    check("uv_off", rst_pin_oe_o, 1'b0);
    check("uv_thr_off", uv_thr, 1'b0);
    check("warn_off", status_o.supply_warning_flag, 1'b0);
    uv_low = 1'b0;
    // crossing inside the reset sequence stays silent
    sw_i.supply_warning_irq_en = 1'b1;
    por(1'b0, 1'b1);
    @(negedge clk_i);
    check("warn_flag", status_o.supply_warning_flag, 1'b1);
    check("warn_thr", warn_thr, 1'b1);
    check("irq_in_reset", irq_o, 1'b0);
    set_cmp(1'b0);
    check("irq_toggle", irq_o, 1'b1);
    check("warn_thr_lo", warn_thr, 1'b0);
    sw_pulse('{isr_enter: 1'b1, default: 1'b0});
    check("irq_isr", irq_o, 1'b0);
    @(negedge clk_i);
    sw_i.supply_warning_irq_en = 1'b0;
    set_cmp(1'b1);
    check("irq_masked", irq_o, 1'b0);
    check("irq_en_echo0", status_o.supply_warning_irq_en, 1'b0);
    sw_i.supply_warning_irq_en = 1'b1;
    repeat (2) @(negedge clk_i);
    check("irq_late_en", irq_o, 1'b1);
    check("irq_en_echo1", status_o.supply_warning_irq_en, 1'b1);
    sw_pulse('{isr_enter: 1'b1, default: 1'b0});
    // watchdog, then a second underflow during the delay restarts it
    pulse_wdg();
    repeat (RM + 3) @(negedge clk_i);
    pulse_wdg();
    hold_check(RM + DS - 1, RM - 1);
    check("wdg_flag", status_o.watchdog_reset_flag, 1'b1);
    sw_pulse('{clr_watchdog_flag: 1'b1, default: 1'b0});
    check("wdg_clr", status_o.watchdog_reset_flag, 1'b0);
    pulse_wdg();
    hold_check(RM + DS - 1, RM - 1);
    // undervoltage: static reset of random length
    seed = lfsr_next(seed);
    len = 20 + int'(seed[4:0]);
    @(negedge clk_i);
    uv_low = 1'b1;
    for (int i = 0; i < len; i++) begin
      @(negedge clk_i);
      check("uv_pin", rst_pin_oe_o, 1'b1);
      check("uv_core", cpu_reset_o, 1'b1);
      check("uv_thr", uv_thr, 1'b1);
    end
    check("uv_flag", status_o.undervoltage_reset_flag, 1'b1);
    check("uv_wdg_clr", status_o.watchdog_reset_flag, 1'b0);
    uv_low = 1'b0;
    hold_check(DS, 0);
    // short external pulse is stretched; flags keep their values
    @(negedge clk_i);
    ext_pull = 1'b1;
    @(negedge clk_i);
    ext_pull = 1'b0;
    hold_check(RM + DS - 2, RM - 2);
    check("ext_uv_keep", status_o.undervoltage_reset_flag, 1'b1);
    check("ext_wdg", status_o.watchdog_reset_flag, 1'b0);
    sw_pulse('{clr_undervoltage_flag: 1'b1, default: 1'b0});
    check("uv_clr", status_o.undervoltage_reset_flag, 1'b0);
    finish_test();
  end

  // hang guard, well past the expected few hundred cycles
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule

`default_nettype wire
